// file: hw/adcmc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcmc_consts.svh"

module adcmc_top
    import adcmc_pkg::*;
(
    // core clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    // serial command link
    input wire logic LINK_CLK,
    input wire logic LINK_VALID,
    input wire adcmc_cmd_t LINK_CMD,
    output logic LINK_READY,
    // configuration
    input wire logic SCAN_MODE,
    input wire logic START_PULSE_IRQ_ENABLE,
    output logic [7:0] POWER_CLOCK_MODE_CONFIG,
    // scan sequencer
    input wire logic SEQ_IDLE_SHDN,
    output logic SCAN_RESTART,
    // converter core
    input wire adcmc_result_t CONV_IN,
    output logic MODULATOR_TICK,
    output logic ADC_HOLD_RESET,
    output logic CONV_RESTART,
    // status and events
    output adcmc_state_t ADC_STATE,
    output logic START_PULSE,
    output logic DATA_READY,
    output logic [15:0] CONVERSION_RESULT,
    output logic FULL_SHDN,
    output logic PARTIAL_SHDN
);

    // ****************************************************
    // command crossing
    // ****************************************************
    logic cmd_pulse;
    adcmc_cmd_t cmd;

    adcmc_cmd_cdc u_cdc (
        .reset_n(RESET_N),
        .link_clk(LINK_CLK),
        .core_clk(CORE_CLK),
        .core_ce(CLK_EN),
        .link_valid(LINK_VALID),
        .link_cmd(LINK_CMD),
        .link_ready(LINK_READY),
        .core_pulse(cmd_pulse),
        .core_cmd(cmd)
    );

    // ****************************************************
    // command decode
    // ****************************************************
    logic cfg_wr;
    logic fc_mode;
    logic fc_full_shdn;
    logic fc_full_reset;
    logic mode_wr;
    logic [1:0] new_mode;
    logic [1:0] fc_code_mode;

    assign cfg_wr = cmd_pulse && !cmd.fast;
    assign fc_full_shdn = cmd_pulse && cmd.fast
        && cmd.data[3:0] == `ADCMC_FC_FULL_SHDN;
    assign fc_full_reset = cmd_pulse && cmd.fast
        && cmd.data[3:0] == `ADCMC_FC_FULL_RESET;

    always_comb
    begin
        fc_mode = 1'b0;
        fc_code_mode = `ADCMC_REQ_SHDN;
        if (cmd_pulse && cmd.fast)
        begin
            unique case (cmd.data[3:0])
                `ADCMC_FC_CONV:
                begin
                    fc_mode = 1'b1;
                    fc_code_mode = `ADCMC_REQ_CONV;
                end
                `ADCMC_FC_STBY:
                begin
                    fc_mode = 1'b1;
                    fc_code_mode = `ADCMC_REQ_STBY;
                end
                `ADCMC_FC_ADC_SHDN:
                begin
                    fc_mode = 1'b1;
                    fc_code_mode = `ADCMC_REQ_SHDN;
                end
                default:
                begin
                    fc_mode = 1'b0;
                    fc_code_mode = `ADCMC_REQ_SHDN;
                end
            endcase
        end
    end

    // fast mode command behaves as a write of the request field
    assign mode_wr = cfg_wr || fc_mode;
    assign new_mode = fc_mode ? fc_code_mode
        : cmd.data[`ADCMC_CFG_MODE_MSB:`ADCMC_CFG_MODE_LSB];

    // ****************************************************
    // configuration register
    // ****************************************************
    logic [7:0] cfg_reg;
    logic full_shdn_reg;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            cfg_reg <= `ADCMC_CFG_RESET;
        else if (CLK_EN)
        begin
            if (fc_full_reset)
                cfg_reg <= `ADCMC_CFG_RESET;
            else if (cfg_wr)
                cfg_reg <= cmd.data;
            else if (fc_mode)
                cfg_reg[`ADCMC_CFG_MODE_MSB:`ADCMC_CFG_MODE_LSB]
                    <= fc_code_mode;
        end
    end

    // only explicit commands touch this flag; the sequencer cannot
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            full_shdn_reg <= 1'b0;
        else if (CLK_EN)
        begin
            if (fc_full_shdn
                || (cfg_wr && cmd.data == `ADCMC_CFG_FULL_SHDN))
                full_shdn_reg <= 1'b1;
            else if (fc_mode || cfg_wr || fc_full_reset)
                full_shdn_reg <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            PARTIAL_SHDN <= 1'b0;
        else if (CLK_EN)
            PARTIAL_SHDN <= cfg_reg[`ADCMC_CFG_CLK_MSB:0] == 6'h00
                && cfg_reg[`ADCMC_CFG_SHDN_MSB:`ADCMC_CFG_SHDN_LSB]
                != 2'h0;
    end

    // readback shows the stored request, so scan reads 11 all cycle
    assign POWER_CLOCK_MODE_CONFIG = cfg_reg;
    assign FULL_SHDN = full_shdn_reg;

    // ****************************************************
    // effective request
    // ****************************************************
    logic [1:0] req_mode;
    logic req_active;
    logic seq_forced;

    assign seq_forced = SCAN_MODE && SEQ_IDLE_SHDN;
    // forced 00 during scan idle is internal and leaves full shutdown alone
    assign req_mode = (full_shdn_reg || seq_forced) ? `ADCMC_REQ_SHDN
        : cfg_reg[`ADCMC_CFG_MODE_MSB:`ADCMC_CFG_MODE_LSB];
    assign req_active = req_mode[1];

    // ****************************************************
    // modulator clock divider
    // ****************************************************
    logic [2:0] div_reg;
    logic mod_tick;

    assign mod_tick = div_reg == `ADCMC_MOD_DIV - 3'h1;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            div_reg <= 3'h0;
        else if (CLK_EN)
        begin
            if (full_shdn_reg || mod_tick)
                div_reg <= 3'h0;
            else
                div_reg <= div_reg + 3'h1;
        end
    end

    assign MODULATOR_TICK = mod_tick && !full_shdn_reg;

    // ****************************************************
    // command synchronisation delay
    // ****************************************************
    logic [1:0] sync_reg;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            sync_reg <= 2'h0;
        else if (CLK_EN)
        begin
            if (full_shdn_reg)
                sync_reg <= 2'h0;
            else if (mode_wr && new_mode[1])
                sync_reg <= `ADCMC_SYNC_DELAY;
            else if (sync_reg != 2'h0)
                sync_reg <= sync_reg - 2'h1;
        end
    end

    // ****************************************************
    // start-up timer and actual state
    // ****************************************************
    adcmc_state_t state_reg;
    adcmc_state_t state_next;
    logic [8:0] settle_reg;
    logic restart;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_SHDN:
                if (req_active)
                    state_next = ST_SETTLE;
            ST_SETTLE:
                if (!req_active)
                    state_next = ST_SHDN;
                else if (settle_reg == 9'h000)
                    state_next = req_mode[0] ? ST_CONV : ST_STBY;
            ST_STBY, ST_CONV:
                if (!req_active)
                    state_next = ST_SHDN;
                else
                    state_next = req_mode[0] ? ST_CONV : ST_STBY;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_reg <= ST_SHDN;
        else if (CLK_EN)
            state_reg <= state_next;
    end

    // rewrites of an unchanged request leave the count alone
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            settle_reg <= `ADCMC_SETTLE_PERIODS;
        else if (CLK_EN)
        begin
            if (state_next == ST_SHDN || full_shdn_reg)
                settle_reg <= `ADCMC_SETTLE_PERIODS;
            else if (state_reg == ST_SETTLE && sync_reg == 2'h0
                && mod_tick && settle_reg != 9'h000)
                settle_reg <= settle_reg - 9'h001;
        end
    end

    assign ADC_STATE = state_reg;
    // standby and settling hold the converter in reset
    assign ADC_HOLD_RESET = state_reg != ST_CONV;

    // ****************************************************
    // restart and start pulses
    // ****************************************************
    assign restart = mode_wr && new_mode == `ADCMC_REQ_CONV
        && !full_shdn_reg;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            CONV_RESTART <= 1'b0;
            SCAN_RESTART <= 1'b0;
            START_PULSE <= 1'b0;
        end
        else if (CLK_EN)
        begin
            CONV_RESTART <= restart && state_reg == ST_CONV
                && state_next == ST_CONV;
            SCAN_RESTART <= restart && SCAN_MODE;
            START_PULSE <= START_PULSE_IRQ_ENABLE
                && ((state_next == ST_CONV && state_reg != ST_CONV)
                || (restart && state_reg == ST_CONV
                && state_next == ST_CONV));
        end
    end

    // ****************************************************
    // conversion result and data ready
    // ****************************************************
    logic take_result;

    // a result finishing in a restart cycle is a discarded partial one
    assign take_result = CONV_IN.done && state_reg == ST_CONV
        && !CONV_RESTART;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            CONVERSION_RESULT <= 16'h0000;
        else if (CLK_EN)
        begin
            if (fc_full_reset)
                CONVERSION_RESULT <= 16'h0000;
            else if (take_result)
                CONVERSION_RESULT <= CONV_IN.data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            DATA_READY <= 1'b0;
        else if (CLK_EN)
            DATA_READY <= take_result;
    end

endmodule

`default_nettype wire

// file: pkg/adcmc_consts.svh
`ifndef ADCMC_CONSTS_SVH
`define ADCMC_CONSTS_SVH

// power_clock_mode_config field layout
`define ADCMC_CFG_MODE_MSB 1
`define ADCMC_CFG_MODE_LSB 0
`define ADCMC_CFG_BURN_MSB 3
`define ADCMC_CFG_BURN_LSB 2
`define ADCMC_CFG_CLK_MSB 5
`define ADCMC_CFG_CLK_LSB 4
`define ADCMC_CFG_SHDN_MSB 7
`define ADCMC_CFG_SHDN_LSB 6
`define ADCMC_CFG_RESET 8'h00
`define ADCMC_CFG_FULL_SHDN 8'h00

// state request codes
`define ADCMC_REQ_CONV 2'h3
`define ADCMC_REQ_STBY 2'h2
`define ADCMC_REQ_SHDN 2'h0

// fast command codes
`define ADCMC_FC_CONV 4'ha
`define ADCMC_FC_STBY 4'hb
`define ADCMC_FC_ADC_SHDN 4'hc
`define ADCMC_FC_FULL_SHDN 4'hd
`define ADCMC_FC_FULL_RESET 4'he

// timing counts
`define ADCMC_SETTLE_PERIODS 9'h100
`define ADCMC_SYNC_DELAY 2'h2
`define ADCMC_MOD_DIV 3'h4

`endif

// file: pkg/adcmc_pkg.sv
package adcmc_pkg;

    // command word passed from the serial side to the core
    typedef struct packed {
        logic fast;
        logic [7:0] data;
    } adcmc_cmd_t;

    // actual analog state, distinct from the requested one
    typedef enum logic [1:0] {
        ST_SHDN = 2'b00,
        ST_SETTLE = 2'b01,
        ST_STBY = 2'b10,
        ST_CONV = 2'b11
    } adcmc_state_t;

    typedef struct packed {
        logic done;
        logic [15:0] data;
    } adcmc_result_t;

endpackage

// file: hw/adcmc_cmd_cdc.sv
`timescale 1ns/1ps
`default_nettype none

module adcmc_cmd_cdc
    import adcmc_pkg::*;
(
    // resets and clocks
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic core_clk,
    input wire logic core_ce,
    // link side
    input wire logic link_valid,
    input wire adcmc_cmd_t link_cmd,
    output logic link_ready,
    // core side
    output logic core_pulse,
    output adcmc_cmd_t core_cmd
);

    // ****************************************************
    // link domain: capture and request toggle
    // ****************************************************
    adcmc_cmd_t hold_reg;
    logic req_tog_reg;
    logic ack_tog_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic busy;

    assign busy = req_tog_reg != ack_sync_reg;
    assign link_ready = !busy;

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_reg <= '0;
            req_tog_reg <= 1'b0;
        end
        else if (link_valid && !busy)
        begin
            hold_reg <= link_cmd;
            req_tog_reg <= !req_tog_reg;
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end
        else
        begin
            ack_meta_reg <= ack_tog_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    // ****************************************************
    // core domain: synchronise toggle, emit pulse, acknowledge
    // ****************************************************
    logic req_meta_reg;
    logic req_sync_reg;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            ack_tog_reg <= 1'b0;
        end
        else if (core_ce)
        begin
            req_meta_reg <= req_tog_reg;
            req_sync_reg <= req_meta_reg;
            ack_tog_reg <= req_sync_reg;
        end
    end

    // hold_reg is stable while the toggle is in flight
    assign core_pulse = core_ce && (req_sync_reg != ack_tog_reg);
    assign core_cmd = hold_reg;

endmodule

`default_nettype wire

// file: test/adcmc_mode_chk.sv
`timescale 1ns/1ps
`default_nettype none

module adcmc_mode_chk
    import adcmc_pkg::*;
(
    // clocks and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic LINK_CLK,
    // link
    input wire logic LINK_VALID,
    input wire logic LINK_READY,
    // config and sequencer
    input wire logic SCAN_MODE,
    input wire logic START_PULSE_IRQ_ENABLE,
    input wire logic [7:0] POWER_CLOCK_MODE_CONFIG,
    input wire logic SCAN_RESTART,
    // converter and status
    input wire adcmc_result_t CONV_IN,
    input wire logic MODULATOR_TICK,
    input wire logic ADC_HOLD_RESET,
    input wire logic CONV_RESTART,
    input wire adcmc_state_t ADC_STATE,
    input wire logic START_PULSE,
    input wire logic DATA_READY,
    input wire logic [15:0] CONVERSION_RESULT,
    input wire logic FULL_SHDN,
    input wire logic PARTIAL_SHDN
);
    // ****************************************
    // settling span counter
    // ****************************************
    logic [11:0] settle_cnt_reg;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            settle_cnt_reg <= 12'h000;
        else if (ADC_STATE != ST_SETTLE)
            settle_cnt_reg <= 12'h000;
        else if (CLK_EN)
            settle_cnt_reg <= settle_cnt_reg + 12'h001;
    end

    a_settle_span: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        $past(ADC_STATE) == ST_SETTLE && ADC_STATE inside {ST_STBY, ST_CONV}
        |-> settle_cnt_reg >= 12'h3fc && settle_cnt_reg <= 12'h410)
        else $error("settling span out of range");
    a_result_kept: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        $changed(CONVERSION_RESULT)
        |-> DATA_READY || CONVERSION_RESULT == 16'h0000)
        else $error("result changed without completion");
    a_result_taken: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && CONV_IN.done && ADC_STATE == ST_CONV && !CONV_RESTART
        |=> DATA_READY && CONVERSION_RESULT == $past(CONV_IN.data))
        else $error("completed result not taken");
    a_ready_cause: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        DATA_READY |-> $past(ADC_STATE) == ST_CONV && $past(CONV_IN.done))
        else $error("data ready without completion");
    a_hold_state: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        ADC_HOLD_RESET == (ADC_STATE != ST_CONV))
        else $error("hold reset disagrees with state");
    a_partial_cfg: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        $past(CLK_EN) |-> PARTIAL_SHDN ==
        ($past(POWER_CLOCK_MODE_CONFIG[5:0]) == 6'h00 &&
        $past(POWER_CLOCK_MODE_CONFIG[7:6]) != 2'h0))
        else $error("partial shutdown flag wrong");
    a_full_quiet: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        FULL_SHDN |-> !MODULATOR_TICK)
        else $error("activity in full shutdown");
    a_full_state: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        FULL_SHDN && CLK_EN |=> ADC_STATE == ST_SHDN)
        else $error("converter not shut down in full shutdown");
    a_shdn_now: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && $fell(POWER_CLOCK_MODE_CONFIG[1])
        |-> ##[0:1] ADC_STATE == ST_SHDN)
        else $error("shutdown not immediate");
    a_start_gate: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        START_PULSE |-> $past(START_PULSE_IRQ_ENABLE))
        else $error("start pulse while disabled");
    a_restart_conv: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        CONV_RESTART |-> $past(ADC_STATE) == ST_CONV)
        else $error("restart outside conversion");
    a_scan_only: assert property (
        @(posedge CORE_CLK) disable iff (!RESET_N)
        SCAN_RESTART |-> $past(SCAN_MODE))
        else $error("scan restart outside scan mode");
    a_link_take: assert property (
        @(posedge LINK_CLK) disable iff (!RESET_N)
        LINK_VALID && LINK_READY |=> !LINK_READY)
        else $error("link ready stayed high after take");
endmodule

bind adcmc_top adcmc_mode_chk chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .LINK_CLK(LINK_CLK), .LINK_VALID(LINK_VALID), .LINK_READY(LINK_READY),
    .SCAN_MODE(SCAN_MODE), .START_PULSE_IRQ_ENABLE(START_PULSE_IRQ_ENABLE),
    .POWER_CLOCK_MODE_CONFIG(POWER_CLOCK_MODE_CONFIG),
    .SCAN_RESTART(SCAN_RESTART), .CONV_IN(CONV_IN),
    .MODULATOR_TICK(MODULATOR_TICK), .ADC_HOLD_RESET(ADC_HOLD_RESET),
    .CONV_RESTART(CONV_RESTART), .ADC_STATE(ADC_STATE),
    .START_PULSE(START_PULSE), .DATA_READY(DATA_READY),
    .CONVERSION_RESULT(CONVERSION_RESULT), .FULL_SHDN(FULL_SHDN),
    .PARTIAL_SHDN(PARTIAL_SHDN)
);

`default_nettype wire

// file: test/adcmc_host.sv
`timescale 1ns/1ps
`default_nettype none

module adcmc_host
    import adcmc_pkg::*;
(
    // link pins
    output logic link_clk,
    output logic link_valid,
    output adcmc_cmd_t link_cmd,
    input wire logic link_ready
);
    logic lraw = 1'b0;
    logic run = 1'b0;

    // link clock only toggles while a command is in flight
    initial
    begin
        link_valid = 1'b0;
        link_cmd = '0;
        #3.7;
        forever #16 lraw = ~lraw;
    end
    assign link_clk = lraw & run;

    task automatic send(input adcmc_cmd_t c, input int gap);
        int n;
        repeat (gap) @(posedge lraw);
        @(negedge lraw);
        run = 1'b1;
        @(posedge lraw);
        link_valid <= 1'b1;
        link_cmd <= c;
        n = 0;
        do
        begin
            @(negedge lraw);
            n++;
        end while (link_ready !== 1'b1 && n < 64);
        @(posedge lraw);
        link_valid <= 1'b0;
        // released lines show the inverse of the last value
        link_cmd <= ~c;
        n = 0;
        do
        begin
            @(negedge lraw);
            n++;
        end while (link_ready !== 1'b1 && n < 64);
        run = 1'b0;
    endtask
endmodule

`default_nettype wire

// file: test/adc_operating_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adc_operating_mode_control_bench
    import adcmc_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic scan_mode = 1'b0;
    logic sp_en = 1'b1;
    logic seq_idle = 1'b0;
    adcmc_result_t conv_in = '0;
    logic link_clk, link_valid, link_ready, scan_rst, tick, hold_rst;
    logic conv_rst, sp, dr, full, part;
    adcmc_cmd_t link_cmd;
    adcmc_state_t state;
    logic [7:0] cfg;
    logic [15:0] result;
    logic [7:0] m_cfg = 8'h00;
    logic m_full = 1'b0;
    logic [15:0] res_q[$];
    logic [7:0] pcfg[4] = '{8'h40, 8'h80, 8'hc0, 8'h01};
    int seed, fail_count, n_compared, n_sp, n_cr, n_sr, n_tk, n_st, t;

    always #4 core_clk = ~core_clk;

    adcmc_host host (.link_clk(link_clk), .link_valid(link_valid),
        .link_cmd(link_cmd), .link_ready(link_ready));

    adcmc_top uut (.CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
        .LINK_CLK(link_clk), .LINK_VALID(link_valid), .LINK_CMD(link_cmd),
        .LINK_READY(link_ready), .SCAN_MODE(scan_mode),
        .START_PULSE_IRQ_ENABLE(sp_en), .POWER_CLOCK_MODE_CONFIG(cfg),
        .SEQ_IDLE_SHDN(seq_idle), .SCAN_RESTART(scan_rst), .CONV_IN(conv_in),
        .MODULATOR_TICK(tick), .ADC_HOLD_RESET(hold_rst),
        .CONV_RESTART(conv_rst), .ADC_STATE(state), .START_PULSE(sp),
        .DATA_READY(dr), .CONVERSION_RESULT(result), .FULL_SHDN(full),
        .PARTIAL_SHDN(part));

    // ****************************************
    // event counters and checking tasks
    // ****************************************
    always @(negedge core_clk)
    begin
        n_sp += int'(sp === 1'b1);
        n_cr += int'(conv_rst === 1'b1);
        n_sr += int'(scan_rst === 1'b1);
        n_tk += int'(tick === 1'b1);
        n_st += int'(state === ST_SETTLE && clk_en === 1'b1);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmd(input logic f, input logic [7:0] d);
        adcmc_cmd_t c;
        // settling span is counted from the command on
        n_st = 0;
        c.fast = f;
        c.data = d;
        host.send(c, $random(seed) & 3);
        repeat (2) @(posedge core_clk);
        #1;
        if (!f)
        begin
            m_cfg = d;
            m_full = (d == 8'h00);
        end
        else if (d[3:0] inside {4'ha, 4'hb, 4'hc})
        begin
            m_cfg[1:0] = (d[3:0] == 4'ha) ? 2'h3
                : (d[3:0] == 4'hb) ? 2'h2 : 2'h0;
            m_full = 1'b0;
        end
        else if (d[3:0] == 4'hd)
        begin
            // full shutdown leaves the configuration untouched
            m_full = 1'b1;
        end
        else if (d[3:0] == 4'he)
        begin
            m_cfg = 8'h00;
            m_full = 1'b0;
            res_q.push_back(16'h0000);
        end
        chk({8'h00, cfg}, {8'h00, m_cfg});
        chk({15'h0, full}, {15'h0, m_full});
        chk(result, res_q[$]);
    endtask

    task automatic conv(input logic ok);
        logic [15:0] d;
        d = 16'($random(seed));
        @(posedge core_clk) conv_in <= {1'b1, d};
        @(posedge core_clk) conv_in <= {1'b0, ~d};
        if (ok)
            res_q.push_back(d);
        #1;
        chk({15'h0, dr}, {15'h0, ok});
        chk(result, res_q[$]);
    endtask

    task automatic settle(input logic stall);
        int w;
        w = 0;
        if (stall)
            repeat (9) @(posedge core_clk) clk_en <= ~clk_en;
        while (state !== ST_CONV && w < 3000)
        begin
            @(posedge core_clk) clk_en <= 1'b1;
            w++;
        end
        #1;
        chk(16'(n_st >= 1020 && n_st <= 1036), 16'h1);
    endtask

    initial
    begin
        #300000;
        fail_count++;
        end_sim();
    end

    initial
    begin
        seed = 54421;
        res_q.push_back(16'h0000);
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1;
        chk({8'h00, cfg}, 16'h0000);
        chk({14'h0, state}, {14'h0, ST_SHDN});
        cmd(1'b0, 8'h43);
        t = n_sp;
        settle(1'b0);
        chk(16'(n_sp - t), 16'h1);
        repeat (3) conv(1'b1);
        for (int i = 0; i < 2; i++)
        begin
            sp_en <= i[0] ? 1'b0 : 1'b1;
            t = n_sp;
            n_cr = 0;
            cmd(1'b1, 8'h0a);
            chk(16'(n_cr), 16'h1);
            chk(16'(n_sp - t), i[0] ? 16'h0 : 16'h1);
        end
        sp_en <= 1'b1;
        cmd(1'b1, 8'h0b);
        chk({13'h0, state, hold_rst}, {13'h0, ST_STBY, 1'b1});
        conv(1'b0);
        cmd(1'b1, 8'h0a);
        chk({14'h0, state}, {14'h0, ST_CONV});
        cmd(1'b0, 8'h00);
        t = n_tk;
        conv(1'b0);
        chk({14'h0, state}, {14'h0, ST_SHDN});
        chk(16'(n_tk - t), 16'h0);
        cmd(1'b1, 8'h0a);
        settle(1'b1);
        foreach (pcfg[i])
        begin
            cmd(1'b0, pcfg[i]);
            chk({15'h0, part}, {15'h0, i != 3});
        end
        cmd(1'b1, 8'h0d);
        cmd(1'b1, 8'h0e);
        scan_mode <= 1'b1;
        cmd(1'b0, 8'h03);
        settle(1'b0);
        seq_idle <= 1'b1;
        repeat (3) @(posedge core_clk);
        cmd(1'b1, 8'h00);
        chk({14'h0, state}, {14'h0, ST_SHDN});
        n_sr = 0;
        cmd(1'b0, 8'h03);
        chk(16'(n_sr), 16'h1);
        @(posedge core_clk) seq_idle <= 1'b0;
        settle(1'b0);
        end_sim();
    end
endmodule

`default_nettype wire
